/* uart_infrared_core.sv */
// Asynchronous serial port with infrared coder, baud clock output,
// auto-baud, break and four-deep transmit and receive buffers.
// Assumes a single-cycle register port with read data one cycle later;
// i_idle comes from the core clock domain, i_rx_pin from outside.
//
// How it works
// RULE1: infrared coding only in 16x baud mode
// RULE2: pin field 11 drives 16x baud clock; the code gives 4x when the high-speed bit is set
// RULE3: infrared enable routes pins through coder
// RULE4: module enable gives pins, else released
// RULE5: stop-in-idle halts module while core idles
// RULE6: auto-baud measures 55h sync, then self-clears
// RULE7: receive polarity bit sets receive idle level
// RULE8: high-speed bit picks 4 or 16 ticks
// RULE9: two-bit field selects data and parity
// RULE10: stop select gives one or two stops
// RULE11: transmit event mode picks firing condition
// RULE12: break sends start, twelve zeros, stop
// RULE13: clearing transmit enable aborts and flushes
// RULE14: buffer-full flag when no room left
// RULE15: shift-empty flag when nothing left to send
// RULE16: receive event mode picks fill level
// RULE17: address detect only in nine-bit format
// RULE18: error flags describe the oldest character
// RULE19: overrun sets; clearing it flushes receiver
// RULE20: data-available flag when buffer holds data
// RULE21: data registers carry nine bits, rest zero
// RULE22: divisor write clears baud timer at once
// RULE23: four-entry buffers for receive and transmit
// RULE24: reading received data advances the buffer
// RULE25: address mode discards non-address characters
// RULE26: start on leaving idle, sample mid-bit
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "uart_ir_regs.svh"
module uart_infrared_core
  import uart_ir_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
)
(
  // Clock and reset.
  input  wire logic      i_core_clk,
  input  wire logic      i_nrst,
  // Register port.
  input  wire bus_req_s  i_bus,
  output logic [15:0]    o_rdata,
  // Core power state.
  input  wire logic      i_idle,
  // Serial pins.
  input  wire logic      i_rx_pin,
  output logic           o_tx_out,
  output logic           o_tx_oe,
  output logic           o_bclk_out,
  output logic           o_bclk_oe,
  // Events.
  output logic           o_tx_event,
  output logic           o_rx_event
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  st_s           s;
  st_s           next_s;
  logic          run;
  logic          ir_on;
  logic          has9;
  logic          tx_nine;
  logic [3:0]    last_sub;
  logic [3:0]    mid_sub;
  logic [3:0]    nbits;
  logic [CW-1:0] tf_cnt;
  logic [CW-1:0] rf_cnt;
  logic          tf_full;
  logic          tf_empty;
  logic          rf_full;
  logic          rf_empty;
  logic [8:0]    tf_head;
  logic [10:0]   rf_head;
  logic [10:0]   rf_data;
  logic          tf_push;
  logic          tf_pop;
  logic          tf_clr;
  logic          rf_push;
  logic          rf_pop;
  logic          rf_clr;
  logic          raw;
  logic          rxd;
  logic          fall;
  logic [11:0]   word;
  logic [11:0]   al;
  logic          stop1;
  logic          stop2;
  logic          parity_error_flag;
  logic          framing_error_flag;
  logic          drop;
  logic          overrun_flag_set;
  logic          overrun_flag_clr;
  logic [22:0]   ab_div;
  logic [15:0]   ab_brg;
  logic [15:0]   mode_rd;
  logic [15:0]   sta_rd;

  function automatic logic par(input logic [7:0] d, input logic odd);
    par = (^d) ^ odd;
  endfunction

  serial_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_txf ( // RULE23
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_clear    (tf_clr),
    .i_push     (tf_push),
    .i_data     (i_bus.wdata[8:0]),
    .i_pop      (tf_pop),
    .o_head     (tf_head),
    .o_count    (tf_cnt)
  );

  serial_fifo #(.W(11), .DEPTH(FIFO_DEPTH)) u_rxf ( // RULE23
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_clear    (rf_clr),
    .i_push     (rf_push),
    .i_data     (rf_data),
    .i_pop      (rf_pop),
    .o_head     (rf_head),
    .o_count    (rf_cnt)
  );

  assign run      = s.en && !(s.sidl && i_idle); // RULE4 RULE5
  assign ir_on    = s.infrared_enable_bit && !s.high_speed_baud_bit; // RULE1 RULE3
  assign has9     = s.pdsel != 2'h0; // RULE9
  assign last_sub = s.high_speed_baud_bit ? `HS_LAST_SUB : `STD_LAST_SUB; // RULE8
  assign mid_sub  = s.high_speed_baud_bit ? `HS_MID_SUB : `STD_MID_SUB; // RULE26
  assign nbits    = 4'hA + {3'h0, has9} + {3'h0, s.stop_bit_select}; // RULE10
  assign tf_full  = tf_cnt == CW'(FIFO_DEPTH);
  assign tf_empty = tf_cnt == '0;
  assign rf_full  = rf_cnt == CW'(FIFO_DEPTH);
  assign rf_empty = rf_cnt == '0;

  // Ninth transmitted bit: data, parity, or an extra stop bit.
  assign tx_nine = (s.pdsel == `PD_NINE) ? tf_head[8] :
                   (s.pdsel == 2'h0) ? 1'b1 :
                   par(tf_head[7:0], s.pdsel[1]); // RULE9

  // Receive line normalised to idle high; infrared pulses are stretched
  // so that the mid-bit sample still sees them.
  assign raw  = s.r2 ^ s.receive_polarity_bit; // RULE7
  assign rxd  = raw && (!ir_on || s.irh == 4'h0); // RULE3
  assign fall = s.rprev && !rxd; // RULE26

  assign word  = {rxd, s.rsh[11:1]};
  assign al    = word >> (4'hC - nbits);
  assign stop1 = has9 ? al[10] : al[9];
  assign stop2 = has9 ? al[11] : al[10];
  assign framing_error_flag  = !stop1 || (s.stop_bit_select && !stop2); // RULE10
  assign parity_error_flag  = (s.pdsel[1] ^ s.pdsel[0]) &&
                 (al[9] != par(al[8:1], s.pdsel[1])); // RULE9
  assign drop  = s.address_detect_enable && s.pdsel == `PD_NINE && !al[9]; // RULE17 RULE25

  assign ab_div = s.high_speed_baud_bit ? (s.abc >> `AB_SHIFT_HS) :
                           (s.abc >> `AB_SHIFT_STD);
  assign ab_brg = (ab_div[15:0] == 16'h0) ? 16'h0 :
                  ab_div[15:0] - 16'h1;

  always_comb
  begin
    mode_rd = 16'h0;
    mode_rd[`MODE_EN]    = s.en;
    mode_rd[`MODE_SIDL]  = s.sidl;
    mode_rd[`MODE_INFRARED_ENABLE_BIT]  = s.infrared_enable_bit;
    mode_rd[9:8]         = s.uen;
    mode_rd[`MODE_AUTO_BAUD_BIT] = s.auto_baud_bit;
    mode_rd[`MODE_RECEIVE_POLARITY_BIT] = s.receive_polarity_bit;
    mode_rd[`MODE_HIGH_SPEED_BAUD_BIT]  = s.high_speed_baud_bit;
    mode_rd[2:1]         = s.pdsel;
    mode_rd[`MODE_STOP_BIT_SELECT] = s.stop_bit_select;
    sta_rd = 16'h0;
    sta_rd[`STA_TXISEL1] = s.txisel[1];
    sta_rd[`STA_TXINV]   = s.txinv;
    sta_rd[`STA_TXISEL0] = s.txisel[0];
    sta_rd[`STA_BRK]     = s.brk;
    sta_rd[`STA_TXEN]    = s.txen;
    sta_rd[`STA_TXBF]    = tf_full; // RULE14
    sta_rd[`STA_SHIFT_REGISTER_EMPTY_FLAG]    = s.txs == TX_IDLE && tf_empty; // RULE15
    sta_rd[7:6]          = s.rxisel;
    sta_rd[`STA_ADDRESS_DETECT_ENABLE]   = s.address_detect_enable;
    sta_rd[`STA_RIDLE]   = s.rxs == RX_IDLE;
    sta_rd[`STA_PARITY_ERROR_FLAG]    = !rf_empty && rf_head[9]; // RULE18
    sta_rd[`STA_FRAMING_ERROR_FLAG]    = !rf_empty && rf_head[10]; // RULE18
    sta_rd[`STA_OVERRUN_FLAG]    = s.overrun_flag;
    sta_rd[`STA_RXDA]    = !rf_empty; // RULE20
  end

  always_comb
  begin
    next_s   = s;
    tf_push  = 1'b0;
    tf_pop   = 1'b0;
    tf_clr   = 1'b0;
    rf_push  = 1'b0;
    rf_pop   = 1'b0;
    rf_clr   = 1'b0;
    rf_data  = {framing_error_flag, parity_error_flag, al[9] && s.pdsel == `PD_NINE, al[8:1]};
    overrun_flag_set = 1'b0;
    overrun_flag_clr = 1'b0;
    next_s.r1    = i_rx_pin;
    next_s.r2    = s.r1;
    next_s.rprev = rxd;
    next_s.rdata = 16'h0;
    next_s.txev  = 1'b0;
    next_s.rxev  = 1'b0;
    next_s.tick  = 1'b0;

    // Baud generator: one tick per divisor period.
    if (run)
    begin
      if (s.bcnt >= s.brg)
      begin
        next_s.bcnt = 16'h0;
        next_s.tick = 1'b1;
      end
      else
        next_s.bcnt = s.bcnt + 16'h1;
    end
    next_s.bclk   = s.bcnt <= (s.brg >> 1);
    next_s.bclkoe = s.en && s.uen == `UEN_BCLK; // RULE2 RULE4

    if (ir_on && !raw)
      next_s.irh = last_sub;
    else if (s.tick && s.irh != 4'h0)
      next_s.irh = s.irh - 4'h1;

    // Transmitter.
    case (s.txs)
      TX_IDLE:
        if (run && s.txen && !tf_empty)
        begin
          tf_pop      = 1'b1;
          next_s.txs  = TX_SHIFT;
          next_s.tsub = 4'h0;
          next_s.tbrk = s.brk;
          if (s.brk)
          begin
            next_s.tsh   = `BRK_FRAME; // RULE12
            next_s.tbits = `BRK_BITS;
          end
          else
          begin
            next_s.tsh   = {5'h1F, tx_nine, tf_head[7:0], 1'b0};
            next_s.tbits = nbits; // RULE10
          end
          next_s.txev = s.txisel == 2'h0 ||
                        (s.txisel == 2'h2 && tf_cnt == CW'(1)); // RULE11
        end
      TX_SHIFT:
        if (s.tick)
        begin
          if (s.tsub == last_sub)
          begin
            next_s.tsub  = 4'h0;
            next_s.tsh   = {1'b1, s.tsh[14:1]};
            next_s.tbits = s.tbits - 4'h1;
            if (s.tbits == 4'h1)
            begin
              next_s.txs  = TX_IDLE;
              next_s.brk  = s.brk && !s.tbrk; // RULE12
              next_s.txev = s.txisel == 2'h1 && tf_empty; // RULE11
            end
          end
          else
            next_s.tsub = s.tsub + 4'h1;
        end
      default:
        next_s.txs = TX_IDLE;
    endcase
    next_s.txo  = (ir_on ? (!s.tsh[0] && s.tsub < `IR_PULSE)
                         : s.tsh[0]) ^ s.txinv; // RULE3
    next_s.txoe = s.en && s.txen; // RULE4 RULE13

    // Receiver.
    case (s.rxs)
      RX_IDLE:
        if (run && fall && !s.auto_baud_bit)
        begin
          next_s.rxs   = RX_DATA; // RULE26
          next_s.rsub  = 4'h0;
          next_s.rbits = 4'h0;
        end
      RX_DATA:
        if (!run)
          next_s.rxs = RX_IDLE;
        else if (s.tick)
        begin
          next_s.rsub = (s.rsub == last_sub) ? 4'h0 : s.rsub + 4'h1;
          if (s.rsub == mid_sub)
          begin
            next_s.rsh   = word; // RULE26
            next_s.rbits = s.rbits + 4'h1;
            if (s.rbits == 4'h0 && rxd)
              next_s.rxs = RX_IDLE;
            else if (s.rbits == nbits - 4'h1)
            begin
              next_s.rxs = RX_IDLE;
              if (!drop && rf_full)
                overrun_flag_set = 1'b1; // RULE19
              else if (!drop)
              begin
                rf_push     = 1'b1;
                next_s.rxev = !s.rxisel[1] || // RULE16
                  rf_cnt == (s.rxisel[0] ? CW'(FIFO_DEPTH - 1)
                                         : CW'(FIFO_DEPTH * 3 / 4 - 1));
              end
            end
          end
        end
      default:
        next_s.rxs = RX_IDLE;
    endcase

    // Auto-baud: five falling edges of the sync byte span eight bits.
    if (s.auto_baud_bit && run)
    begin
      if (s.abe != 3'h0)
        next_s.abc = s.abc + 23'h1;
      if (fall)
      begin
        if (s.abe == 3'h0)
        begin
          next_s.abe = 3'h1;
          next_s.abc = 23'h1;
        end
        else if (s.abe == `AB_EDGES)
        begin
          next_s.auto_baud_bit = 1'b0; // RULE6
          next_s.abe   = 3'h0;
          next_s.brg   = ab_brg;
          next_s.bcnt  = 16'h0;
        end
        else
          next_s.abe = s.abe + 3'h1;
      end
    end
    else
      next_s.abe = 3'h0;

    // Register writes.
    if (i_bus.wr)
    begin
      case (i_bus.addr)
        `OFS_MODE:
        begin
          next_s.en    = i_bus.wdata[`MODE_EN];
          next_s.sidl  = i_bus.wdata[`MODE_SIDL];
          next_s.infrared_enable_bit  = i_bus.wdata[`MODE_INFRARED_ENABLE_BIT];
          next_s.uen   = i_bus.wdata[9:8];
          next_s.auto_baud_bit = i_bus.wdata[`MODE_AUTO_BAUD_BIT]; // RULE6
          next_s.receive_polarity_bit = i_bus.wdata[`MODE_RECEIVE_POLARITY_BIT];
          next_s.high_speed_baud_bit  = i_bus.wdata[`MODE_HIGH_SPEED_BAUD_BIT];
          next_s.pdsel = i_bus.wdata[2:1];
          next_s.stop_bit_select = i_bus.wdata[`MODE_STOP_BIT_SELECT];
        end
        `OFS_STA:
        begin
          next_s.txisel = {i_bus.wdata[`STA_TXISEL1],
                           i_bus.wdata[`STA_TXISEL0]};
          next_s.txinv  = i_bus.wdata[`STA_TXINV];
          next_s.brk    = i_bus.wdata[`STA_BRK];
          next_s.txen   = i_bus.wdata[`STA_TXEN];
          if (s.txen && !i_bus.wdata[`STA_TXEN])
          begin
            tf_clr     = 1'b1; // RULE13
            next_s.txs = TX_IDLE;
            next_s.tsh = '1;
          end
          next_s.rxisel = i_bus.wdata[7:6];
          next_s.address_detect_enable  = i_bus.wdata[`STA_ADDRESS_DETECT_ENABLE];
          if (s.overrun_flag && !i_bus.wdata[`STA_OVERRUN_FLAG])
          begin
            overrun_flag_clr   = 1'b1; // RULE19
            rf_clr     = 1'b1;
            next_s.rxs = RX_IDLE;
          end
        end
        `OFS_TXD:
          tf_push = 1'b1; // RULE21
        `OFS_BRG:
        begin
          next_s.brg  = i_bus.wdata;
          next_s.bcnt = 16'h0; // RULE22
        end
        default:
          next_s.brg = s.brg;
      endcase
    end
    next_s.overrun_flag = overrun_flag_set || (s.overrun_flag && !overrun_flag_clr); // RULE19

    // Register reads; data stands in the following cycle only.
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        `OFS_MODE:
          next_s.rdata = mode_rd;
        `OFS_STA:
          next_s.rdata = sta_rd;
        `OFS_RXD:
        begin
          next_s.rdata = {7'h00, rf_head[8:0]}; // RULE21
          rf_pop       = !rf_empty; // RULE24
        end
        `OFS_BRG:
          next_s.rdata = s.brg;
        default:
          next_s.rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s     <= '0;
      s.tsh <= '1;
      s.brg <= `RST_BRG;
    end
    else
      s <= next_s;
  end

  assign o_rdata    = s.rdata;
  assign o_tx_out   = s.txo;
  assign o_tx_oe    = s.txoe;
  assign o_bclk_out = s.bclk;
  assign o_bclk_oe  = s.bclkoe;
  assign o_tx_event = s.txev;
  assign o_rx_event = s.rxev;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence brk_load;
    s.txs == TX_IDLE && run && s.txen && !tf_empty && s.brk;
  endsequence

  sequence brk_frame;
    s.txs == TX_SHIFT && s.tbits == `BRK_BITS && s.tsh == `BRK_FRAME;
  endsequence

  brg_write_clr_a: assert property ( // RULE22
    i_bus.wr && i_bus.addr == `OFS_BRG |=>
      s.bcnt == 16'h0 && s.brg == $past(i_bus.wdata))
    else $error("divisor write did not clear baud timer");

  sta_flags_a: assert property ( // RULE14 RULE20
    i_bus.rd && i_bus.addr == `OFS_STA |=>
      o_rdata[`STA_TXBF] == $past(tf_full) &&
      o_rdata[`STA_RXDA] == $past(!rf_empty))
    else $error("status buffer flags wrong");

  shift_empty_a: assert property ( // RULE15
    i_bus.rd && i_bus.addr == `OFS_STA |=>
      o_rdata[`STA_SHIFT_REGISTER_EMPTY_FLAG] == $past(s.txs == TX_IDLE && tf_empty))
    else $error("shift empty flag wrong");

  tx_abort_a: assert property ( // RULE13
    $fell(s.txen) |-> ##1 !o_tx_oe && tf_cnt == '0)
    else $error("transmit disable did not abort");

  bclk_pin_a: assert property ( // RULE2
    s.en && s.uen == `UEN_BCLK |=> o_bclk_oe)
    else $error("baud clock pin not enabled");

  break_frame_a: assert property ( // RULE12
    brk_load |=> brk_frame)
    else $error("break frame not loaded");

  overrun_set_a: assert property ( // RULE19
    overrun_flag_set |=> s.overrun_flag && rf_cnt == $past(rf_cnt))
    else $error("overrun not flagged");

  rx_event_a: assert property ( // RULE16
    rf_push && !s.rxisel[1] |=> o_rx_event ##1 !o_rx_event)
    else $error("receive event missing");

  tx_event_a: assert property ( // RULE11
    tf_pop && s.txisel == 2'h0 |=> o_tx_event)
    else $error("transmit event missing");

  addr_drop_a: assert property ( // RULE25
    s.rxs == RX_DATA && drop |-> !rf_push)
    else $error("non-address character stored");
endmodule
`default_nettype wire

/* uart_ir_regs.svh */
// Register offsets, field positions, reset values and timing counts of the
// infrared-capable serial port. Definitions only; include by bare name.
`ifndef UART_IR_REGS_SVH
`define UART_IR_REGS_SVH

`define OFS_MODE      3'h0
`define OFS_STA       3'h1
`define OFS_TXD       3'h2
`define OFS_RXD       3'h3
`define OFS_BRG       3'h4

`define MODE_EN       15
`define MODE_SIDL     13
`define MODE_INFRARED_ENABLE_BIT     12
`define MODE_AUTO_BAUD_BIT    5
`define MODE_RECEIVE_POLARITY_BIT    4
`define MODE_HIGH_SPEED_BAUD_BIT     3
`define MODE_STOP_BIT_SELECT    0

`define STA_TXISEL1   15
`define STA_TXINV     14
`define STA_TXISEL0   13
`define STA_BRK       11
`define STA_TXEN      10
`define STA_TXBF      9
`define STA_SHIFT_REGISTER_EMPTY_FLAG      8
`define STA_ADDRESS_DETECT_ENABLE     5
`define STA_RIDLE     4
`define STA_PARITY_ERROR_FLAG      3
`define STA_FRAMING_ERROR_FLAG      2
`define STA_OVERRUN_FLAG      1
`define STA_RXDA      0

`define RST_BRG       16'h0000
`define UEN_BCLK      2'h3
`define PD_NINE       2'h3
`define FIFO_DEPTH    4

`define STD_LAST_SUB  4'hF
`define STD_MID_SUB   4'h7
`define HS_LAST_SUB   4'h3
`define HS_MID_SUB    4'h1
`define IR_PULSE      4'h3
`define BRK_FRAME     15'h6000
`define BRK_BITS      4'hE
`define AB_EDGES      3'h4
`define AB_SHIFT_STD  7
`define AB_SHIFT_HS   5

`endif

/* uart_ir_pkg.sv */
// Types shared by the serial port core.
// Assumes the register header is compiled alongside.
package uart_ir_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } bus_req_s;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_e;
  typedef enum logic {RX_IDLE, RX_DATA} rx_e;

  typedef struct packed {
    logic        en, sidl, infrared_enable_bit;
    logic [1:0]  uen;
    logic        auto_baud_bit, receive_polarity_bit, high_speed_baud_bit;
    logic [1:0]  pdsel;
    logic        stop_bit_select;
    logic [1:0]  txisel;
    logic        txinv, brk, txen;
    logic [1:0]  rxisel;
    logic        address_detect_enable, overrun_flag;
    logic [15:0] brg, bcnt;
    logic        tick;
    tx_e         txs;
    logic [14:0] tsh;
    logic [3:0]  tbits, tsub;
    logic        tbrk;
    rx_e         rxs;
    logic [11:0] rsh;
    logic [3:0]  rbits, rsub;
    logic        r1, r2, rprev;
    logic [3:0]  irh;
    logic [2:0]  abe;
    logic [22:0] abc;
    logic [15:0] rdata;
    logic        txo, txoe, bclk, bclkoe, txev, rxev;
  } st_s;

endpackage

/* serial_fifo.sv */
// First-in first-out buffer with synchronous clear.
// Assumes a push when full and a pop when empty are ignored.
`timescale 1ns/100ps
`default_nettype none
`include "uart_ir_regs.svh"
module serial_fifo
#(
  parameter int W     = 9,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
)
(
  // Clock and reset.
  input  wire logic          i_core_clk,
  input  wire logic          i_nrst,
  // Requests.
  input  wire logic          i_clear,
  input  wire logic          i_push,
  input  wire logic [W-1:0]  i_data,
  input  wire logic          i_pop,
  // State.
  output logic      [W-1:0]  o_head,
  output logic      [AW:0]   o_count
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fst_s;

  fst_s          s;
  fst_s          next_s;
  logic [W-1:0]  mem [DEPTH];
  logic          do_push;
  logic          do_pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("serial_fifo depth must be a power of two of at least 2");
  end

  assign do_push = i_push && s.cnt != (AW+1)'(DEPTH) && !i_clear;
  assign do_pop  = i_pop && s.cnt != '0 && !i_clear;
  assign o_head  = mem[s.rp];
  assign o_count = s.cnt;

  always_comb
  begin
    next_s = s;
    if (i_clear)
      next_s = '0;
    else
    begin
      if (do_push)
        next_s.wp = s.wp + 1'b1;
      if (do_pop)
        next_s.rp = s.rp + 1'b1;
      next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      s <= '0;
    else
      s <= next_s;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (do_push)
      mem[s.wp] <= i_data;
  end
endmodule
`default_nettype wire

/* serial_peer.sv */
// Remote serial peer: drives the receive line and captures transmit frames.
// Assumes the bench sets the bit period in core clocks and the echo choice.
`timescale 1ns/100ps
`default_nettype none
module serial_peer
(
  // Clock.
  input  wire logic        i_core_clk,
  // Link control from the bench.
  input  wire logic [7:0]  i_per,
  input  wire logic        i_echo,
  // Device pins.
  input  wire logic        i_tx_out,
  input  wire logic        i_tx_oe,
  output logic             o_rx_line
);
  logic        drv = 1'b1;
  logic        line;
  logic [12:0] cap = '1;
  int          got = 0;

  // A released transmit pin is pulled up to the idle level.
  assign line = i_tx_oe ? i_tx_out : 1'b1;
  assign o_rx_line = i_echo ? line : drv;

  // Samples thirteen bit periods, mid-bit, from each falling edge.
  always
  begin
    @(negedge line);
    repeat (i_per / 2) @(posedge i_core_clk);
    for (int i = 0; i < 13; i++)
    begin
      cap[i] = line;
      repeat (i_per) @(posedge i_core_clk);
    end
    got++;
  end

  task automatic send(input logic [12:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      drv <= bits[i];
      repeat (i_per) @(posedge i_core_clk);
    end
    drv <= 1'b1;
    @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

/* uart_infrared_core_test.sv */
// Self-checking bench for the serial port core with a remote peer model.
// Assumes the package is compiled first and the peer model beside it.
`timescale 1ns/100ps
`default_nettype none
module uart_infrared_core_test
  import uart_ir_pkg::*;
;
  typedef struct packed {
    logic       hs;
    logic [1:0] pd;
    logic       st;
    logic [8:0] d;
  } row_s;

  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        idle = 1'b0;
  bus_req_s    bus = '0;
  logic [15:0] rdata;
  logic        rx_pin;
  logic        tx_out;
  logic        tx_oe;
  logic        bclk;
  logic        bclk_oe;
  logic        tx_ev;
  logic        rx_ev;
  logic [7:0]  per = 8'h10;
  logic        echo = 1'b0;
  logic [15:0] v;
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          t0 = 0;
  int          t1 = 0;
  int          rxn = 0;
  int          n;
  int          span;
  row_s        rows [7] = '{'{1'b0, 2'h0, 1'b0, 9'h0A5},
                            '{1'b0, 2'h1, 1'b0, 9'h03C},
                            '{1'b0, 2'h2, 1'b1, 9'h081},
                            '{1'b0, 2'h3, 1'b0, 9'h1C3},
                            '{1'b1, 2'h1, 1'b1, 9'h007},
                            '{1'b1, 2'h3, 1'b1, 9'h055},
                            '{1'b1, 2'h0, 1'b0, 9'h0FF}};

  uart_infrared_core u_dut
  (
    .i_core_clk (core_clk),
    .i_nrst     (nrst),
    .i_bus      (bus),
    .o_rdata    (rdata),
    .i_idle     (idle),
    .i_rx_pin   (rx_pin),
    .o_tx_out   (tx_out),
    .o_tx_oe    (tx_oe),
    .o_bclk_out (bclk),
    .o_bclk_oe  (bclk_oe),
    .o_tx_event (tx_ev),
    .o_rx_event (rx_ev)
  );

  serial_peer u_peer
  (
    .i_core_clk (core_clk),
    .i_per      (per),
    .i_echo     (echo),
    .i_tx_out   (tx_out),
    .i_tx_oe    (tx_oe),
    .o_rx_line  (rx_pin)
  );

  initial
  begin
    forever #4 core_clk = ~core_clk;
  end

  // Times the first start bit of a frame and the transmit event.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (tx_ev)
      t1 <= cyc;
    if (t0 == 0 && tx_oe && !tx_out)
      t0 <= cyc;
    if (rx_ev)
      rxn <= rxn + 1;
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic wait_frame();
    int n0;
    n0 = u_peer.got;
    for (int k = 0; k < 3000 && u_peer.got == n0; k++)
      @(posedge core_clk);
  endtask

  function automatic logic [15:0] frame(input row_s r);
    logic [12:0] f;
    f = {4'hF, r.d[7:0], 1'b0};
    if (r.pd == 2'h3)
      f[9] = r.d[8];
    else if (r.pd != 2'h0)
      f[9] = ^r.d[7:0] ^ (r.pd == 2'h2);
    return {3'h0, f};
  endfunction

  task automatic stop_test();
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    rd(3'h1, v);
    chk("status reset", 16'h0110, v);
    wr(3'h7, 16'hFFFF);
    rd(3'h7, v);
    chk("unmapped read", 16'h0000, v);
    rd(3'h0, v);
    chk("mode reset", 16'h0000, v);
    echo <= 1'b1;
    foreach (rows[i])
    begin
      per <= rows[i].hs ? 8'h04 : 8'h10;
      wr(3'h0, {12'h800, rows[i].hs, rows[i].pd, rows[i].st});
      wr(3'h1, 16'h2400);
      t0 = 0;
      rxn = 0;
      wr(3'h2, {7'h0, rows[i].d});
      wait_frame();
      n = 10 + int'(rows[i].pd != 2'h0) + int'(rows[i].st);
      span = t1 - t0;
      chk("tx frame", frame(rows[i]), {3'h0, u_peer.cap});
      chk("tx span", 16'h0001, {15'h0, span >= (n - 1) * per
          && span <= (n + 1) * per});
      chk("rx events", 16'h0001, rxn[15:0]);
      rd(3'h1, v);
      chk("rx status", 16'h0001, v & 16'h000F);
      rd(3'h3, v);
      chk("rx data", {7'h0, rows[i].pd == 2'h3 && rows[i].d[8],
          rows[i].d[7:0]}, v);
    end
    echo <= 1'b0;
    per <= 8'h10;
    wr(3'h0, 16'h8000);
    wr(3'h1, 16'h00C0);
    rxn = 0;
    for (int i = 0; i < 5; i++)
      u_peer.send({4'hF, i[7:0], 1'b0}, 10);
    repeat (4) @(posedge core_clk);
    chk("full event", 16'h0001, rxn[15:0]);
    rd(3'h1, v);
    chk("overrun", 16'h0003, v & 16'h0003);
    wr(3'h1, 16'h0000);
    rd(3'h1, v);
    chk("rx flushed", 16'h0000, v & 16'h0003);
    wr(3'h0, 16'h8002);
    u_peer.send({2'h3, 1'b1, 1'b1, 8'h03, 1'b0}, 11);
    u_peer.send({2'h3, 1'b1, 1'b0, 8'h03, 1'b0}, 11);
    rd(3'h1, v);
    chk("parity top", 16'h0009, v & 16'h000F);
    rd(3'h3, v);
    chk("bad char", 16'h0003, v);
    rd(3'h1, v);
    chk("next top", 16'h0001, v & 16'h000F);
    rd(3'h3, v);
    wr(3'h0, 16'h8001);
    u_peer.send({2'h3, 1'b0, 1'b1, 8'h5A, 1'b0}, 12);
    rd(3'h1, v);
    chk("stop error", 16'h0005, v & 16'h000F);
    rd(3'h3, v);
    wr(3'h0, 16'h8006);
    wr(3'h1, 16'h0020);
    u_peer.send({3'h7, 1'b0, 8'h21, 1'b0}, 11);
    u_peer.send({3'h7, 1'b1, 8'h42, 1'b0}, 11);
    rd(3'h3, v);
    chk("address only", 16'h0142, v);
    wr(3'h0, 16'h8000);
    wr(3'h1, 16'h0000);
    repeat (4) wr(3'h2, 16'h0011);
    rd(3'h1, v);
    chk("tx full", 16'h0200, v & 16'h0300);
    wr(3'h1, 16'h0400);
    repeat (2) @(posedge core_clk);
    chk("tx drive", 16'h0001, {15'h0, tx_oe});
    wr(3'h1, 16'h0000);
    rd(3'h1, v);
    chk("tx flushed", 16'h0100, v & 16'h0300);
    chk("tx released", 16'h0000, {15'h0, tx_oe});
    repeat (260) @(posedge core_clk);
    wr(3'h1, 16'h0C00);
    wr(3'h2, 16'h0000);
    wait_frame();
    chk("break bits", 16'h0000, {3'h0, u_peer.cap});
    repeat (40) @(posedge core_clk);
    rd(3'h1, v);
    chk("break done", 16'h0000, v & 16'h0800);
    wr(3'h0, 16'hA000);
    idle <= 1'b1;
    wr(3'h2, 16'h0033);
    repeat (40) @(posedge core_clk);
    chk("idle halt", 16'h0001, {15'h0, tx_out});
    idle <= 1'b0;
    wait_frame();
    chk("resume", frame('{1'b0, 2'h0, 1'b0, 9'h033}),
        {3'h0, u_peer.cap});
    repeat (40) @(posedge core_clk);
    wr(3'h0, 16'h9300);
    repeat (2) @(posedge core_clk);
    chk("baud clock pin", 16'h0003, {14'h0, bclk_oe, bclk});
    chk("infrared idle", 16'h0000, {15'h0, tx_out});
    wr(3'h0, 16'h0000);
    repeat (2) @(posedge core_clk);
    chk("pins released", 16'h0000, {14'h0, bclk_oe, tx_oe});
    per <= 8'h20;
    wr(3'h4, 16'h0005);
    rd(3'h4, v);
    chk("divisor", 16'h0005, v);
    wr(3'h0, 16'h8020);
    u_peer.send({4'hF, 8'h55, 1'b0}, 10);
    rd(3'h4, v);
    chk("auto baud", 16'h0001, v);
    rd(3'h0, v);
    chk("auto clear", 16'h8000, v);
    stop_test();
  end
endmodule
`default_nettype wire
